// file: nfc_nvm_ctrl.sv
// Nonvolatile memory controller: flash, data EEPROM, latches and protection.
`timescale 1ns/1ns
`default_nettype none
module nfc_nvm_ctrl #(
  parameter int unsigned WRITE_CYCLES = nfc_pkg::WRITE_CYC,
  parameter int unsigned ERASE_CYCLES = nfc_pkg::ERASE_CYC
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [14:0]      fetch_addr,
  output logic      [13:0]      fetch_data,
  input  wire logic             ind_rd,
  input  wire logic             ind_ee,
  input  wire logic [14:0]      indirect_pointer_register,
  output logic      [13:0]      indirect_data_port,
  output logic                  ind_valid,
  input  wire logic             nvm_reg_valid,
  input  wire nfc_pkg::nfc_cmd_t nvm_reg_cmd,
  input  wire logic             nvm_reg_ee,
  input  wire logic [14:0]      nvm_reg_addr,
  input  wire logic [5:0]       nvm_write_data_high,
  input  wire logic [7:0]       nvm_write_data_low,
  output logic      [13:0]      nvm_reg_rd_data,
  output logic                  nvm_reg_done,
  output logic                  nvm_reg_err,
  input  wire logic             pgm_valid,
  input  wire nfc_pkg::nfc_cmd_t pgm_cmd,
  input  wire logic             pgm_ee,
  input  wire logic [14:0]      pgm_addr,
  input  wire logic [13:0]      pgm_wdata,
  output logic      [13:0]      pgm_rd_data,
  output logic                  pgm_done,
  output logic                  pgm_err,
  output logic                  busy
);
  import nfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  if (WRITE_CYCLES < MIN_CYC || ERASE_CYCLES < MIN_CYC) begin : g_chk
    $error("nfc_nvm_ctrl: program or erase time too short");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state.
  // user flash and extra row
  logic [13:0] flash_mem [0:USER_WORDS-1];  // User program words.
  logic [13:0] extra_mem [0:EXTRA_WORDS-1]; // IDs, configuration, vectors.
  logic [7:0]  ee_mem    [0:EE_BYTES-1];    // Data EEPROM bytes.
  logic [13:0] latch_q   [0:ROW_WORDS-1];   // Hidden write latches.
  logic [ROW_WORDS-1:0] latch_vld_q;        // Latches loaded since last write.
  nfc_state_t  state_q;                     // Sequencer state.
  nfc_cmd_t    op_cmd_q;                    // Operation being timed.
  logic        op_ee_q;                     // Operation targets EEPROM.
  logic        op_pgm_q;                    // Operation came from programmer.
  logic [14:0] op_addr_q;                   // Operation address.
  logic [14:0] cnt_q;                       // Word index while applying.
  logic [13:0] cfg3_q;                      // Copy of configuration word 3.
  logic [13:0] cfg4_q;                      // Copy of configuration word 4.
  logic        tmr_done;                    // Timer finished.

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // True for commands that change the memory.
  function automatic logic is_mod(input nfc_cmd_t c);
    is_mod = (c == CMD_WRITE) || (c == CMD_ROW_ERASE) || (c == CMD_BULK_ERASE);
  endfunction

  // True when a user flash address lies in the write protected span.
  function automatic logic wp_hit(input logic [1:0] f, input logic [13:0] a);
    wp_hit = (f == WP_ALL) || ((f == WP_HALF) && (a < WP_HALF_END)) ||
             ((f == WP_LOW) && (a < WP_LOW_END));
  endfunction

  // One word from either memory.
  function automatic logic [13:0] nvm_read(input logic ee, input logic [14:0] a);
    if (ee) begin
      nvm_read = {6'h00, ee_mem[a[7:0]]};
    end else if (a[EXTRA_BIT]) begin
      nvm_read = extra_mem[a[4:0]];
    end else begin
      nvm_read = flash_mem[a[13:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request checking and selection.
  logic        prog_cp_on;  // Program flash code protection active.
  logic        ee_cp_on;    // EEPROM code protection active.
  logic        pgm_block;   // Programmer access hit by code protection.
  logic        pgm_ref;     // Programmer request refused.
  logic        pgm_acc;     // Programmer request taken.
  logic        reg_ref;     // Register request refused.
  logic        reg_acc;     // Register request taken.
  nfc_cmd_t    sel_cmd;     // Command of the taken request.
  logic        sel_ee;      // Region of the taken request.
  logic [14:0] sel_addr;    // Address of the taken request.
  logic [13:0] sel_wdata;   // Latch data of the taken request.
  logic [13:0] sel_word;    // Memory word at the taken address.
  logic        start_mod;   // A timed operation begins.
  logic        apply_last;  // Last word of the apply phase.

  // Protection bits are active low so that an erased word disables them.
  assign prog_cp_on = ~cfg4_q[CP_BIT];
  assign ee_cp_on   = ~cfg4_q[CPD_BIT];

  // programmer blocked by protection; no write protect check here
  assign pgm_block = (pgm_cmd != CMD_BULK_ERASE) && (pgm_cmd != CMD_LOAD) &&
                     ((pgm_ee && ee_cp_on) || (!pgm_ee && !pgm_addr[EXTRA_BIT] && prog_cp_on));
  assign pgm_ref = pgm_valid && ((busy && pgm_cmd != CMD_READ) || pgm_block ||
                                 (pgm_cmd > CMD_BULK_ERASE));
  assign pgm_acc = pgm_valid && !pgm_ref;

  // write protect and no bulk erase on the self path; no code check
  assign reg_ref = nvm_reg_valid && (pgm_valid || (busy && nvm_reg_cmd != CMD_READ) ||
                   (nvm_reg_cmd >= CMD_BULK_ERASE) ||
                   (is_mod(nvm_reg_cmd) && !nvm_reg_ee &&
                    (nvm_reg_addr[EXTRA_BIT] ||
                     wp_hit(cfg3_q[WP_LSB+1:WP_LSB], nvm_reg_addr[13:0]))));
  assign reg_acc = nvm_reg_valid && !reg_ref;

  // The programmer port has priority; only it takes the bulk erase command.
  // self path latch data comes from the high and low data pair; programmer data from pgm_wdata
  always_comb begin
    if (pgm_acc) begin
      sel_cmd   = pgm_cmd;
      sel_ee    = pgm_ee;
      sel_addr  = pgm_addr;
      sel_wdata = pgm_wdata;
    end else begin
      sel_cmd   = nvm_reg_cmd;
      sel_ee    = nvm_reg_ee;
      sel_addr  = nvm_reg_addr;
      sel_wdata = {nvm_write_data_high, nvm_write_data_low};
    end
  end

  // A process rather than a continuous assignment, so that a change of the
  // memory contents behind an unchanged address is seen as well.
  always_comb begin
    sel_word = nvm_read(sel_ee, sel_addr);
  end
  assign start_mod = (pgm_acc || reg_acc) && is_mod(sel_cmd);
  assign busy      = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: wait for the timer, then apply the change word by word.
  // row ops span 32 words; EEPROM ops one byte; bulk spans user flash
  always_comb begin
    if (op_cmd_q == CMD_BULK_ERASE) begin
      apply_last = (cnt_q == 15'(USER_WORDS - 1));
    end else if (op_ee_q) begin
      apply_last = 1'b1;
    end else begin
      apply_last = (cnt_q == 15'(ROW_WORDS - 1));
    end
  end

  // the state waits on the internal timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (start_mod) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            state_q <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          cnt_q <= cnt_q + 15'h0001;
          if (apply_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture the operation when it is taken.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_cmd_q  <= CMD_READ;
      op_ee_q   <= 1'b0;
      op_pgm_q  <= 1'b0;
      op_addr_q <= '0;
    end else if (start_mod) begin
      op_cmd_q  <= sel_cmd;
      op_ee_q   <= sel_ee;
      op_pgm_q  <= pgm_acc;
      op_addr_q <= sel_addr;
    end
  end

  // Timer for the program or erase pulse.
  nfc_op_timer #(
    .CNT_W (32)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (start_mod),
    .cycles (sel_cmd == CMD_WRITE ? 32'(WRITE_CYCLES) : 32'(ERASE_CYCLES)),
    .done   (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write latches.
  // load one latch; cleared after the row is written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_vld_q <= '0;
    end else if ((pgm_acc || reg_acc) && sel_cmd == CMD_LOAD) begin
      latch_vld_q[sel_addr[4:0]] <= 1'b1;
    end else if (state_q == ST_APPLY && apply_last && op_cmd_q == CMD_WRITE) begin
      latch_vld_q <= '0;
    end
  end

  // Latch data has no reset; the valid bits guard it.
  always_ff @(posedge clk) begin
    if ((pgm_acc || reg_acc) && sel_cmd == CMD_LOAD) begin
      latch_q[sel_addr[4:0]] <= sel_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory update during the apply phase; contents are nonvolatile.
  logic [4:0]  row_i;  // Word within the row.
  logic [13:0] row_a;  // User flash address of that word.
  assign row_i = cnt_q[4:0];
  assign row_a = {op_addr_q[13:5], row_i};

  always_ff @(posedge clk) begin
    if (state_q == ST_APPLY) begin
      case (op_cmd_q)
        // bulk clears flash, extra row and EEPROM
        CMD_BULK_ERASE: begin
          flash_mem[cnt_q[13:0]] <= ERASED_WORD;
          if (cnt_q < 15'(EXTRA_WORDS)) begin
            extra_mem[cnt_q[4:0]] <= ERASED_WORD;
          end
          if (cnt_q < 15'(EE_BYTES)) begin
            ee_mem[cnt_q[7:0]] <= ERASED_BYTE;
          end
        end
        CMD_ROW_ERASE: begin
          if (op_ee_q) begin
            ee_mem[op_addr_q[7:0]] <= ERASED_BYTE;
          end else if (op_addr_q[EXTRA_BIT]) begin
            extra_mem[row_i] <= ERASED_WORD;
          end else begin
            flash_mem[row_a] <= ERASED_WORD;
          end
        end
        // program loaded latches; flash words by clearing bits only, EEPROM bytes overwritten
        CMD_WRITE: begin
          if (op_ee_q) begin
            if (latch_vld_q[op_addr_q[4:0]]) begin
              ee_mem[op_addr_q[7:0]] <= latch_q[op_addr_q[4:0]][7:0];
            end
          end else if (latch_vld_q[row_i]) begin
            if (op_addr_q[EXTRA_BIT]) begin
              extra_mem[row_i] <= extra_mem[row_i] & latch_q[row_i];
            end else begin
              flash_mem[row_a] <= flash_mem[row_a] & latch_q[row_i];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Configuration copies follow the extra row after reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg3_q <= CFG_RESET;
      cfg4_q <= CFG_RESET;
    end else begin
      cfg3_q <= extra_mem[CFG3_IDX];
      cfg4_q <= extra_mem[CFG4_IDX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read paths and answers.
  // fetch and indirect reads, no write port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_data         <= '0;
      indirect_data_port <= '0;
      ind_valid          <= 1'b0;
    end else begin
      fetch_data <= nvm_read(1'b0, fetch_addr);
      ind_valid  <= ind_rd;
      if (ind_rd) begin
        indirect_data_port <= nvm_read(ind_ee, indirect_pointer_register);
      end
    end
  end

  // one word per read, one done pulse per taken request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvm_reg_rd_data <= '0;
      pgm_rd_data     <= '0;
      nvm_reg_done    <= 1'b0;
      nvm_reg_err     <= 1'b0;
      pgm_done        <= 1'b0;
      pgm_err         <= 1'b0;
    end else begin
      if (reg_acc && sel_cmd == CMD_READ) begin
        nvm_reg_rd_data <= sel_word;
      end
      if (pgm_acc && sel_cmd == CMD_READ) begin
        pgm_rd_data <= sel_word;
      end
      nvm_reg_done <= (reg_acc && !is_mod(sel_cmd)) ||
                      (state_q == ST_APPLY && apply_last && !op_pgm_q);
      pgm_done     <= (pgm_acc && !is_mod(sel_cmd)) ||
                      (state_q == ST_APPLY && apply_last && op_pgm_q);
      nvm_reg_err  <= reg_ref;
      pgm_err      <= pgm_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_busy_refuse;
    busy && nvm_reg_valid && is_mod(nvm_reg_cmd)
      |=> nvm_reg_err && $stable(op_cmd_q) && $stable(op_addr_q);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("modify taken while busy");

  property p_timed;
    $rose(busy) |-> busy[*8];
  endproperty
  a_timed: assert property (p_timed) else $error("operation shorter than timer");

  property p_cp_block;
    pgm_valid && pgm_cmd == CMD_READ && !pgm_ee && !pgm_addr[EXTRA_BIT] && prog_cp_on
      |=> pgm_err && !pgm_done;
  endproperty
  a_cp_block: assert property (p_cp_block) else $error("protected read answered");

  property p_self_no_bulk;
    nvm_reg_valid && nvm_reg_cmd == CMD_BULK_ERASE |=> nvm_reg_err && !nvm_reg_done;
  endproperty
  a_self_no_bulk: assert property (p_self_no_bulk) else $error("self bulk taken");

  property p_wp_block;
    nvm_reg_valid && nvm_reg_cmd == CMD_WRITE && !nvm_reg_ee && !nvm_reg_addr[EXTRA_BIT] &&
      wp_hit(cfg3_q[WP_LSB+1:WP_LSB], nvm_reg_addr[13:0]) |=> nvm_reg_err && !$rose(busy);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected self write taken");

  property p_pgm_free;
    pgm_valid && !busy && pgm_cmd == CMD_WRITE && !pgm_ee && !prog_cp_on |=> !pgm_err && busy;
  endproperty
  a_pgm_free: assert property (p_pgm_free) else $error("programmer write refused");

  property p_read_one;
    reg_acc && nvm_reg_cmd == CMD_READ |=> nvm_reg_done && nvm_reg_rd_data == $past(sel_word);
  endproperty
  a_read_one: assert property (p_read_one) else $error("read word wrong");

  property p_latch_load;
    reg_acc && nvm_reg_cmd == CMD_LOAD |=> latch_vld_q[$past(nvm_reg_addr[4:0])];
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_bulk_clears;
    state_q == ST_APPLY && op_cmd_q == CMD_BULK_ERASE && apply_last |=> ##1 !prog_cp_on && !ee_cp_on;
  endproperty
  a_bulk_clears: assert property (p_bulk_clears) else $error("bulk left protection");

  c_row_write: cover property (state_q == ST_APPLY && op_cmd_q == CMD_WRITE && apply_last);
  c_bulk: cover property (state_q == ST_APPLY && op_cmd_q == CMD_BULK_ERASE && apply_last);
  c_refused: cover property (busy && nvm_reg_err);
endmodule
`default_nettype wire

// file: nfc_pkg.sv
// Shared constants, commands and states of the nonvolatile memory controller.
package nfc_pkg;

  // Memory geometry.
  localparam int unsigned USER_WORDS  = 16384;
  localparam int unsigned EXTRA_WORDS = 32;
  localparam int unsigned ROW_WORDS   = 32;
  localparam int unsigned EE_BYTES    = 256;
  localparam int unsigned WORD_W      = 14;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned EXTRA_BIT   = 14;

  // Erased values: an erase drives every bit to one.
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // Configuration words inside the extra row, and their fields.
  localparam logic [4:0]  CFG3_IDX    = 5'h07;
  localparam logic [4:0]  CFG4_IDX    = 5'h08;
  localparam int unsigned WP_LSB      = 0;
  localparam int unsigned CP_BIT      = 0;
  localparam int unsigned CPD_BIT     = 1;
  localparam logic [13:0] CFG_RESET   = 14'h0000;

  // Write protect field codes and the ends of the protected spans.
  localparam logic [1:0]  WP_ALL      = 2'h0;
  localparam logic [1:0]  WP_HALF     = 2'h1;
  localparam logic [1:0]  WP_LOW      = 2'h2;
  localparam logic [13:0] WP_LOW_END  = 14'h0200;
  localparam logic [13:0] WP_HALF_END = 14'h2000;

  // Timing: clock rate and program or erase durations.
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned T_WRITE_US  = 2000;
  localparam int unsigned T_ERASE_US  = 2000;
  localparam int unsigned WRITE_CYC   = T_WRITE_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC   = T_ERASE_US * CLK_MHZ;
  localparam int unsigned MIN_CYC     = 8;

  // Commands shared by the register interface and the programmer port.
  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,
    CMD_LOAD       = 3'h1,
    CMD_WRITE      = 3'h2,
    CMD_ROW_ERASE  = 3'h3,
    CMD_BULK_ERASE = 3'h4
  } nfc_cmd_t;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_APPLY = 3'b100
  } nfc_state_t;

endpackage

// file: nfc_op_timer.sv
// Down counter that times one program or erase pulse.
`timescale 1ns/1ns
`default_nettype none
module nfc_op_timer #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  done
);
  import nfc_pkg::*;

  logic [CNT_W-1:0] cnt_q;  // Cycles still to run.
  logic             run_q;  // Timer is counting.

  // A counter narrower than four bits is refused.
  if (CNT_W < 4) begin : g_chk
    $error("nfc_op_timer: counter too narrow");
  end

  // Load on start, count down, and pulse done when the count is spent.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= run_q && (cnt_q == '0);
      if (start) begin
        cnt_q <= cycles - 1'b1;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: nfc_prog_model.sv
// Behavioural external programmer that issues requests on the programmer port.
`timescale 1ns/1ns
`default_nettype none
module nfc_prog_model (
  input  wire logic         clk,
  output nfc_pkg::nfc_cmd_t pgm_cmd,
  output logic              pgm_valid,
  output logic              pgm_ee,
  output logic [14:0]       pgm_addr,
  output logic [13:0]       pgm_wdata
);
  import nfc_pkg::*;

  // The port is quiet at time zero.
  initial begin
    pgm_valid = 1'b0;
    pgm_cmd   = CMD_READ;
    pgm_ee    = 1'b0;
    pgm_addr  = 15'h0000;
    pgm_wdata = 14'h0000;
  end

  // Holds one request for exactly one sampling edge, then inverts the idle address and data.
  // latch word sent whole
  task automatic send(input nfc_cmd_t c, input logic e, input logic [14:0] a,
                      input logic [13:0] d);
    pgm_cmd   = c;
    pgm_ee    = e;
    pgm_addr  = a;
    pgm_wdata = d;
    pgm_valid = 1'b1;
    @(posedge clk);
    #1;
    pgm_valid = 1'b0;
    pgm_addr  = ~a;
    pgm_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// file: nvm_flash_control_tb.sv
// Self-checking testbench for the nonvolatile memory controller.
`timescale 1ns/1ns
`default_nettype none
module nvm_flash_control_tb;
  import nfc_pkg::*;
  localparam int unsigned NCYC  = 16;                     // Shortened pulse time.
  // The timer's done flag is registered, so the wait phase lasts one cycle more.
  localparam int unsigned LROW  = NCYC + 2 + ROW_WORDS;   // Flash row operation.
  localparam int unsigned LEE   = NCYC + 3;               // EEPROM operation.
  localparam int unsigned LBLK  = NCYC + 2 + USER_WORDS;  // Bulk erase.
  localparam int unsigned LIMIT = 40000;                  // Watchdog ceiling.
  // Kind: 0 self done, 1 programmer done, 2 indirect, 3 self refusal, 4 programmer refusal.
  typedef struct {int k; logic [13:0] dat; bit chk; int unsigned at;} nfc_note_t;
  nfc_note_t         q[$];
  int unsigned       cyc, failures, total_checks;
  logic              clk, resetn, ind_rd, ind_ee, nvm_reg_valid, nvm_reg_ee;
  logic [14:0]       fetch_addr, ptr, nvm_reg_addr;
  logic [5:0]        nvm_write_data_high;
  logic [7:0]        nvm_write_data_low;
  logic [13:0]       fetch_data, indirect_data_port, nvm_reg_rd_data, pgm_rd_data;
  logic [13:0]       d0, d1, d2, d3;
  logic              ind_valid, nvm_reg_done, nvm_reg_err, pgm_done, pgm_err, busy;
  logic              pgm_valid, pgm_ee;
  logic [14:0]       pgm_addr;
  logic [13:0]       pgm_wdata;
  nfc_cmd_t          nvm_reg_cmd, pgm_cmd;

  nfc_nvm_ctrl #(.WRITE_CYCLES(NCYC), .ERASE_CYCLES(NCYC)) i_dut (.clk, .resetn,
    .fetch_addr, .fetch_data, .ind_rd, .ind_ee, .indirect_pointer_register(ptr),
    .indirect_data_port, .ind_valid, .nvm_reg_valid, .nvm_reg_cmd, .nvm_reg_ee,
    .nvm_reg_addr, .nvm_write_data_high, .nvm_write_data_low, .nvm_reg_rd_data,
    .nvm_reg_done, .nvm_reg_err, .pgm_valid, .pgm_cmd, .pgm_ee, .pgm_addr, .pgm_wdata,
    .pgm_rd_data, .pgm_done, .pgm_err, .busy);
  nfc_prog_model u_prog (.clk, .pgm_cmd, .pgm_valid, .pgm_ee, .pgm_addr, .pgm_wdata);

  always #5 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Compares a directly sampled value.
  task automatic chk_val(input logic [13:0] got, input logic [13:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Takes the oldest note of one kind and checks arrival cycle and data.
  task automatic take(input int k, input logic [13:0] d);
    int i;
    i = 0;
    while (i < q.size() && q[i].k != k) i++;
    total_checks++;
    if (i == q.size()) begin
      failures++;
      $display("BAD %0t unexpected response of kind %0d", $time, k);
    end else begin
      if (q[i].at != cyc || (q[i].chk && d !== q[i].dat)) begin
        failures++;
        $display("BAD %0t kind %0d cycle %0d data %h want %h", $time, k, cyc, d, q[i].dat);
      end
      q.delete(i);
    end
  endtask

  // Response watcher; sees registered outputs before this edge updates them.
  always @(posedge clk) begin
    if (resetn === 1'b1) begin
      if (nvm_reg_done === 1'b1) take(0, nvm_reg_rd_data);
      if (pgm_done === 1'b1) take(1, pgm_rd_data);
      if (ind_valid === 1'b1) take(2, indirect_data_port);
      if (nvm_reg_err === 1'b1) take(3, 14'h0000);
      if (pgm_err === 1'b1) take(4, 14'h0000);
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end

  // Issues one request from software (s=0) or the programmer (s=1) and notes the answer.
  task automatic req(input int s, input bit err, input nfc_cmd_t c, input logic e,
                     input logic [14:0] a, input logic [13:0] d, input int lat,
                     input logic [13:0] x, input bit wt);
    nfc_note_t n;
    repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    #1;
    n.k = s + (err ? 3 : 0);
    n.dat = x;
    n.chk = !err && c == CMD_READ;
    n.at = cyc + (err ? 1 : lat);
    q.push_back(n);
    if (s == 1) u_prog.send(c, e, a, d);
    else begin
      nvm_reg_cmd = c;
      nvm_reg_ee = e;
      nvm_reg_addr = a;
      {nvm_write_data_high, nvm_write_data_low} = d;
      nvm_reg_valid = 1'b1;
      @(posedge clk);
      #1;
      nvm_reg_valid = 1'b0;
      nvm_reg_addr = ~a;
      {nvm_write_data_high, nvm_write_data_low} = ~d;
    end
    // busy from the cycle after a timed operation is taken
    if (!err && c inside {CMD_WRITE, CMD_ROW_ERASE, CMD_BULK_ERASE}) chk_val(14'(busy), 14'h0001, "busy");
    while (wt && q.size() != 0) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Loads one latch word and programs it; the write may be expected to be refused.
  task automatic prog(input int s, input logic e, input logic [14:0] a, input logic [13:0] d,
                      input int lat, input bit err);
    req(s, 1'b0, CMD_LOAD, e, a, d, 1, 14'h0000, 1'b1);
    req(s, err, CMD_WRITE, e, a, 14'h0000, lat, 14'h0000, 1'b1);
  endtask

  task automatic rd(input int s, input logic e, input logic [14:0] a, input logic [13:0] x);
    req(s, 1'b0, CMD_READ, e, a, 14'h0000, 1, x, 1'b1);
  endtask

  // Holds reset for twelve cycles; protection settings reload on release.
  task automatic do_reset();
    @(posedge clk);
    #1;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk_val(14'(busy), 14'h0000, "busy in reset");
    resetn = 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Main sequence.
  initial begin
    {clk, resetn, ind_rd, ind_ee, nvm_reg_valid, nvm_reg_ee} = '0;
    {fetch_addr, ptr, nvm_reg_addr, nvm_write_data_high, nvm_write_data_low} = '0;
    nvm_reg_cmd = CMD_READ;
    cyc = 0;
    failures = 0;
    total_checks = 0;
    void'($urandom(75157));
    {d0, d1, d2, d3} = {14'($urandom), 14'($urandom), 14'($urandom), 14'($urandom)};
    do_reset();
    req(1, 0, CMD_BULK_ERASE, 0, 15'h0000, 14'h0000, LBLK, 14'h0000, 1);
    do_reset();
    rd(1, 0, 15'h0005, 14'h3fff);
    $display("test bulk erase done");
    req(0, 0, CMD_LOAD, 0, 15'h0000, d0, 1, 14'h0000, 1);
    req(0, 0, CMD_LOAD, 0, 15'h0001, d1, 1, 14'h0000, 1);
    req(0, 0, CMD_WRITE, 0, 15'h0040, 14'h0000, LROW, 14'h0000, 0);
    req(0, 1, CMD_WRITE, 0, 15'h0040, 14'h0000, 1, 14'h0000, 1);
    rd(1, 0, 15'h0040, d0);
    rd(1, 0, 15'h0041, d1);
    rd(0, 0, 15'h0042, 14'h3fff);
    req(0, 1, CMD_BULK_ERASE, 0, 15'h0000, 14'h0000, 1, 14'h0000, 1);
    prog(0, 0, 15'h0042, d2, LROW, 0);
    rd(1, 0, 15'h0042, d2);
    rd(1, 0, 15'h0040, d0);
    $display("test row program done");
    rd(0, 0, 15'h0041, d1);
    req(0, 0, CMD_ROW_ERASE, 0, 15'h0041, 14'h0000, LROW, 14'h0000, 1);
    rd(1, 0, 15'h005f, 14'h3fff);
    rd(1, 0, 15'h0040, 14'h3fff);
    prog(0, 0, 15'h0041, d1, LROW, 0);
    prog(0, 0, 15'h0041, d3, LROW, 0);
    rd(0, 0, 15'h0041, d1 & d3);
    prog(0, 1, 15'h0023, d2, LEE, 0);
    $display("test erase and modify done");
    fetch_addr = 15'h0041;
    ptr = 15'h0023;
    ind_ee = 1'b1;
    ind_rd = 1'b1;
    q.push_back('{2, {6'h00, d2[7:0]}, 1'b1, cyc + 1});
    @(posedge clk);
    #1;
    ind_rd = 1'b0;
    chk_val(fetch_data, d1 & d3, "fetch");
    @(posedge clk);
    #1;
    chk_val(14'(q.size()), 14'h0000, "indirect answer");
    $display("test read paths done");
    prog(1, 0, 15'h4007, 14'h0000, LROW, 0);
    prog(1, 0, 15'h4008, 14'h0000, LROW, 0);
    do_reset();
    rd(1, 0, 15'h4007, 14'h0000);
    req(1, 1, CMD_READ, 0, 15'h0040, 14'h0000, 1, 14'h0000, 1);
    req(1, 1, CMD_READ, 1, 15'h0023, 14'h0000, 1, 14'h0000, 1);
    req(1, 1, CMD_WRITE, 0, 15'h0040, 14'h0000, 1, 14'h0000, 1);
    prog(0, 0, 15'h0060, d0, LROW, 1);
    req(0, 1, CMD_ROW_ERASE, 0, 15'h0060, 14'h0000, 1, 14'h0000, 1);
    req(0, 0, CMD_ROW_ERASE, 1, 15'h0023, 14'h0000, LEE, 14'h0000, 1);
    rd(0, 1, 15'h0023, 14'h00ff);
    req(1, 0, CMD_BULK_ERASE, 0, 15'h0000, 14'h0000, LBLK, 14'h0000, 1);
    do_reset();
    rd(1, 0, 15'h0041, 14'h3fff);
    rd(1, 1, 15'h0023, 14'h00ff);
    rd(1, 0, 15'h4008, 14'h3fff);
    $display("test protection done");
    final_report();
  end
endmodule
`default_nettype wire
